// ### simd_dispatch_defines.svh
`ifndef SIMD_DISPATCH_DEFINES_SVH
`define SIMD_DISPATCH_DEFINES_SVH

// ----------------------------------------------------------------
// Lane layout
// ----------------------------------------------------------------
`define WORD_W        32
`define OCTET_W       8
`define HALF_W        16
`define LANE_EXT_W    17
`define LANE_CNT      4
`define HALF_CNT      2
`define REG_IDX_W     5
`define CNT_W         4

// ----------------------------------------------------------------
// Predicate field of the instruction word
// ----------------------------------------------------------------
`define CREG_MSB      31
`define CREG_LSB      29
`define ZTEST_BIT     28
`define CREG_NONE     3'h0
`define CREG_B0       3'h1
`define CREG_B1       3'h2
`define CREG_B2       3'h3
`define CREG_A1       3'h4
`define CREG_A2       3'h5
`define CREG_A0       3'h6
`define CREG_RSVD     3'h7

// Bit positions in the condition-zero vector
`define CZ_A0         0
`define CZ_A1         1
`define CZ_A2         2
`define CZ_B0         3
`define CZ_B1         4
`define CZ_B2         5
`define CZ_W          6

// Bit positions in the unit mask
`define UM_LOGIC      0
`define UM_MULT       1
`define UM_SHIFT      2
`define UM_DATA       3
`define UM_W          4

`endif

// ### simd_dispatch_pkg.sv
`default_nettype none
package simd_dispatch_pkg;

  // Target functional unit
  typedef enum logic [1:0] {
    unit_logic, unit_mult, unit_shift, unit_data
  } unit_t;

  // Extension instruction classes
  typedef enum logic [5:0] {
    op_packed_mpy, op_dot_product, op_average, op_bit_count,
    op_bit_reverse, op_shuffle, op_deinterleave, op_rotate,
    op_galois_quad_multiply, op_delayed_register_move,
    op_sat_var_shift, op_bit_expand,
    op_branch_decrement, op_branch_with_idle, op_branch_if_positive,
    op_pc_relative_add, op_packed_compare, op_sat_packed_add,
    op_packed_shift_right, op_sat_pack, op_octet_unpack,
    op_packed_abs, op_quad_octet_addsub, op_packed_maxmin,
    op_octet_pack, op_octet_abs_difference, op_octet_swap,
    op_halves_pack, op_halves_swap, op_merge_octet_shift,
    op_logic_and, op_logic_andn, op_logic_or, op_logic_xor,
    op_constant_move, op_halves_addsub,
    op_load_double_aligned, op_load_word_unaligned,
    op_load_double_unaligned, op_store_double_aligned,
    op_store_word_unaligned, op_store_double_unaligned,
    op_address_add_doubleword
  } op_class_t;

  // Scalar operand extraction kinds
  typedef enum logic [2:0] {
    signed_lower_half, signed_upper_half,
    unsigned_lower_half, unsigned_upper_half,
    signed_octet, unsigned_octet, whole_word
  } ext_kind_t;

  // Type of the operand read over the cross path
  typedef enum logic [1:0] {
    xk_int, xk_packed_halves, xk_packed_octets, xk_other
  } xkind_t;

  // Packed compare relation
  typedef enum logic [1:0] {
    cmp_eq, cmp_gt, cmp_lt
  } cmp_mode_t;

endpackage : simd_dispatch_pkg
`default_nettype wire

// ### lane_unpack.sv
`timescale 1ns/1ps
`default_nettype none
`include "simd_dispatch_defines.svh"

module lane_unpack (
  // Source word and interpretation
  input  wire logic                         word_signed_in,
  input  wire logic                         octets_in,
  input  wire logic [`WORD_W-1:0]           word_in,
  // Extended lanes, lane 0 lowest
  output logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] lanes_out
);

  // ----------------------------------------------------------------
  // Per-lane extension, no carry between lanes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LANE_CNT; g = g + 1) begin : g_lane
      logic [`OCTET_W-1:0] oct;
      logic                oct_top;
      assign oct     = word_in[g*`OCTET_W +: `OCTET_W];
      assign oct_top = word_signed_in & oct[`OCTET_W-1];
      if (g < `HALF_CNT) begin : g_half
        logic [`HALF_W-1:0] hw;
        logic               hw_top;
        assign hw     = word_in[g*`HALF_W +: `HALF_W];
        assign hw_top = word_signed_in & hw[`HALF_W-1];
        assign lanes_out[g] = octets_in ?
          {{(`LANE_EXT_W-`OCTET_W){oct_top}}, oct} :
          {{(`LANE_EXT_W-`HALF_W){hw_top}}, hw};
      end else begin : g_oct
        assign lanes_out[g] = octets_in ?
          {{(`LANE_EXT_W-`OCTET_W){oct_top}}, oct} :
          {`LANE_EXT_W{1'b0}};
      end
    end
  endgenerate

endmodule : lane_unpack
`default_nettype wire

// ### simd_ext_unit_dispatch_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "simd_dispatch_defines.svh"

// Behaviour
// - Octet lanes numbered from bit 0: lane 0 bits 0-7, lane 3 24-31.
// - Signed octet sign-extends, unsigned octet zero-extends.
// - Half operands take lower or upper half, signed or unsigned.
// - Packed halves are two independent 16-bit values, no carry between.
// - Packed octets are four independent 8-bit values, signed or unsigned.
// - 64-bit result: upper word to odd register, lower word to even.
// - A register pair yields four packed 16-bit values.
// - Bit reverse swaps bit 0 with 31 across the whole word.
// - Bit count counts set bits separately in each octet.
// - Packed compares give one flag per lane: two or four.
// - Predicate register zero or nonzero decides execute or no-operation.
// - Cross path allowed only for integer, packed halves, packed octets.
// - Multiply-only class list goes only to the multiply unit.
// - Double and unaligned loads, stores, address add only on data unit.
// - Branches, compares, saturating adds, shifts, packs, unpacks: shift.
// - Abs, quad add/sub, max/min, octet pack, abs diff, swap: logic.
// - Half pack, half swap, merge shifts on logic and shift units.
// - Logic ops, constant move, half add/sub also on data unit.
// - Selector bits 31-29 include A0; bit 28 is zero test.
module simd_ext_unit_dispatch_decode
  import simd_dispatch_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          arst_n_in,
  // Dispatch request
  input  wire logic                          valid_in,
  input  wire simd_dispatch_pkg::op_class_t  op_class_in,
  input  wire simd_dispatch_pkg::unit_t      unit_sel_in,
  input  wire logic [`WORD_W-1:0]            instr_word_in,
  input  wire logic [`CZ_W-1:0]              cond_is_zero_in,
  input  wire logic                          cross_use_in,
  input  wire simd_dispatch_pkg::xkind_t     cross_kind_in,
  // Operands and lane controls
  input  wire logic [`WORD_W-1:0]            src1_in,
  input  wire logic [`WORD_W-1:0]            src2_in,
  input  wire logic                          lanes_signed_in,
  input  wire logic                          lanes_octets_in,
  input  wire simd_dispatch_pkg::cmp_mode_t  cmp_mode_in,
  input  wire simd_dispatch_pkg::ext_kind_t  ext_kind_in,
  input  wire logic [1:0]                    ext_lane_in,
  input  wire logic [`WORD_W-1:0]            pair_even_in,
  input  wire logic [`WORD_W-1:0]            pair_odd_in,
  // Wide result to split
  input  wire logic                          res64_valid_in,
  input  wire logic [2*`WORD_W-1:0]          res64_in,
  input  wire logic [`REG_IDX_W-1:0]         res64_dst_in,
  // Dispatch decision
  output logic                               issue_out,
  output logic [`UM_W-1:0]                   unit_grant_out,
  output logic                               illegal_out,
  output logic                               squash_out,
  // Lane results
  output logic [`WORD_W-1:0]                 scalar_out,
  output logic [`LANE_CNT-1:0]               flags_out,
  output logic [`WORD_W-1:0]                 bitrev_out,
  output logic [`LANE_CNT*`CNT_W-1:0]        bitcount_out,
  output logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] quad_halves_out,
  // Register pair write
  output logic                               wr_pair_out,
  output logic [`REG_IDX_W-1:0]              wr_even_idx_out,
  output logic [`REG_IDX_W-1:0]              wr_odd_idx_out,
  output logic [`WORD_W-1:0]                 wr_even_data_out,
  output logic [`WORD_W-1:0]                 wr_odd_data_out
);

  import simd_dispatch_pkg::*;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Units allowed for each class
  function automatic logic [`UM_W-1:0] unit_mask(input op_class_t op);
    logic [`UM_W-1:0] m;
    m = '0;
    case (op)
      op_packed_mpy, op_dot_product, op_average, op_bit_count,
      op_bit_reverse, op_shuffle, op_deinterleave, op_rotate,
      op_galois_quad_multiply, op_delayed_register_move,
      op_sat_var_shift, op_bit_expand: begin
        m[`UM_MULT] = 1'b1;
      end
      op_branch_decrement, op_branch_with_idle, op_branch_if_positive,
      op_pc_relative_add, op_packed_compare, op_sat_packed_add,
      op_packed_shift_right, op_sat_pack, op_octet_unpack: begin
        m[`UM_SHIFT] = 1'b1;
      end
      op_packed_abs, op_quad_octet_addsub, op_packed_maxmin,
      op_octet_pack, op_octet_abs_difference, op_octet_swap: begin
        m[`UM_LOGIC] = 1'b1;
      end
      op_halves_pack, op_halves_swap, op_merge_octet_shift: begin
        m[`UM_LOGIC] = 1'b1;
        m[`UM_SHIFT] = 1'b1;
      end
      op_logic_and, op_logic_andn, op_logic_or, op_logic_xor,
      op_constant_move, op_halves_addsub: begin
        m[`UM_LOGIC] = 1'b1;
        m[`UM_SHIFT] = 1'b1;
        m[`UM_DATA]  = 1'b1;
      end
      op_load_double_aligned, op_load_word_unaligned,
      op_load_double_unaligned, op_store_double_aligned,
      op_store_word_unaligned, op_store_double_unaligned,
      op_address_add_doubleword: begin
        m[`UM_DATA] = 1'b1;
      end
      default: m = '0;
    endcase
    return m;
  endfunction : unit_mask

  // Predicate: {reserved, execute}
  function automatic logic [1:0] pred_eval(input logic [2:0] creg,
                                           input logic z,
                                           input logic [`CZ_W-1:0] cz);
    logic sel_zero;
    logic rsvd;
    sel_zero = 1'b0;
    rsvd     = 1'b0;
    case (creg)
      `CREG_NONE: rsvd     = z;
      `CREG_B0:   sel_zero = cz[`CZ_B0];
      `CREG_B1:   sel_zero = cz[`CZ_B1];
      `CREG_B2:   sel_zero = cz[`CZ_B2];
      `CREG_A1:   sel_zero = cz[`CZ_A1];
      `CREG_A2:   sel_zero = cz[`CZ_A2];
      `CREG_A0:   sel_zero = cz[`CZ_A0];
      default:    rsvd     = 1'b1;
    endcase
    if (creg == `CREG_NONE) begin
      return {rsvd, ~rsvd};
    end
    return {rsvd, ~rsvd & (z ? sel_zero : ~sel_zero)};
  endfunction : pred_eval

  // Unit enum to one-hot
  function automatic logic [`UM_W-1:0] unit_onehot(input unit_t u);
    logic [`UM_W-1:0] oh;
    oh = '0;
    case (u)
      unit_logic: oh[`UM_LOGIC] = 1'b1;
      unit_mult:  oh[`UM_MULT]  = 1'b1;
      unit_shift: oh[`UM_SHIFT] = 1'b1;
      unit_data:  oh[`UM_DATA]  = 1'b1;
      default:    oh = '0;
    endcase
    return oh;
  endfunction : unit_onehot

  // ----------------------------------------------------------------
  // Dispatch check
  // ----------------------------------------------------------------
  logic [`UM_W-1:0] sel_oh;
  logic             unit_ok;
  logic             cross_ok;
  logic [1:0]       pred;
  logic             illegal_next;
  logic             exec_next;

  assign sel_oh = unit_onehot(unit_sel_in);
  assign unit_ok = |(sel_oh & unit_mask(op_class_in));
  assign cross_ok = ~cross_use_in | (cross_kind_in != xk_other);
  assign pred = pred_eval(instr_word_in[`CREG_MSB:`CREG_LSB],
                          instr_word_in[`ZTEST_BIT], cond_is_zero_in);
  assign illegal_next = ~unit_ok | ~cross_ok | pred[1];
  assign exec_next    = ~illegal_next & pred[0];

  // Decision registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      issue_out      <= 1'b0;
      unit_grant_out <= '0;
      illegal_out    <= 1'b0;
      squash_out     <= 1'b0;
    end else begin
      issue_out      <= valid_in & exec_next;
      unit_grant_out <= (valid_in & exec_next) ? sel_oh : '0;
      illegal_out    <= valid_in & illegal_next;
      squash_out     <= valid_in & ~illegal_next & ~pred[0];
    end
  end

  // ----------------------------------------------------------------
  // Lane unpacking
  // ----------------------------------------------------------------
  logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] lanes1;
  logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] lanes2;
  logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] lanes_lo;
  logic [`LANE_CNT-1:0][`LANE_EXT_W-1:0] lanes_hi;

  lane_unpack u_src1 (
    .word_signed_in (lanes_signed_in),
    .octets_in      (lanes_octets_in),
    .word_in        (src1_in),
    .lanes_out      (lanes1)
  );

  lane_unpack u_src2 (
    .word_signed_in (lanes_signed_in),
    .octets_in      (lanes_octets_in),
    .word_in        (src2_in),
    .lanes_out      (lanes2)
  );

  lane_unpack u_pair_lo (
    .word_signed_in (lanes_signed_in),
    .octets_in      (1'b0),
    .word_in        (pair_even_in),
    .lanes_out      (lanes_lo)
  );

  lane_unpack u_pair_hi (
    .word_signed_in (lanes_signed_in),
    .octets_in      (1'b0),
    .word_in        (pair_odd_in),
    .lanes_out      (lanes_hi)
  );

  // ----------------------------------------------------------------
  // Scalar extraction
  // ----------------------------------------------------------------
  logic [`OCTET_W-1:0] oct_sel;
  logic [`WORD_W-1:0]  scalar_next;

  assign oct_sel = src2_in[ext_lane_in*`OCTET_W +: `OCTET_W];

  // Half and octet extraction
  always_comb begin
    case (ext_kind_in)
      signed_lower_half:
        scalar_next = {{`HALF_W{src2_in[`HALF_W-1]}},
                       src2_in[`HALF_W-1:0]};
      signed_upper_half:
        scalar_next = {{`HALF_W{src2_in[`WORD_W-1]}},
                       src2_in[`WORD_W-1:`HALF_W]};
      unsigned_lower_half:
        scalar_next = {{`HALF_W{1'b0}}, src2_in[`HALF_W-1:0]};
      unsigned_upper_half:
        scalar_next = {{`HALF_W{1'b0}}, src2_in[`WORD_W-1:`HALF_W]};
      signed_octet:
        scalar_next = {{(`WORD_W-`OCTET_W){oct_sel[`OCTET_W-1]}},
                       oct_sel};
      unsigned_octet:
        scalar_next = {{(`WORD_W-`OCTET_W){1'b0}}, oct_sel};
      default:
        scalar_next = src2_in;
    endcase
  end

  // ----------------------------------------------------------------
  // Packed compare flags, bit reverse, bit count
  // ----------------------------------------------------------------
  logic [`LANE_CNT-1:0]        flags_next;
  logic [`WORD_W-1:0]          bitrev_next;
  logic [`LANE_CNT*`CNT_W-1:0] bitcount_next;

  genvar g;
  generate
    for (g = 0; g < `LANE_CNT; g = g + 1) begin : g_cmp
      logic live;
      logic eq;
      logic gt;
      logic [`CNT_W-1:0] cnt;
      assign live = lanes_octets_in | (g < `HALF_CNT);
      assign eq   = lanes1[g] == lanes2[g];
      assign gt   = $signed(lanes1[g]) > $signed(lanes2[g]);
      assign flags_next[g] = live &
        ((cmp_mode_in == cmp_eq) ? eq :
         (cmp_mode_in == cmp_gt) ? gt : (~gt & ~eq));
      always_comb begin
        cnt = '0;
        for (int b = 0; b < `OCTET_W; b++) begin
          cnt = cnt + {{(`CNT_W-1){1'b0}}, src2_in[g*`OCTET_W+b]};
        end
      end
      assign bitcount_next[g*`CNT_W +: `CNT_W] = cnt;
    end
    for (g = 0; g < `WORD_W; g = g + 1) begin : g_rev
      assign bitrev_next[g] = src2_in[`WORD_W-1-g];
    end
  endgenerate

  // Lane result registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scalar_out      <= '0;
      flags_out       <= '0;
      bitrev_out      <= '0;
      bitcount_out    <= '0;
      quad_halves_out <= '0;
    end else if (valid_in) begin
      scalar_out      <= scalar_next;
      flags_out       <= flags_next;
      bitrev_out      <= bitrev_next;
      bitcount_out    <= bitcount_next;
      quad_halves_out <= {lanes_hi[1], lanes_hi[0],
                          lanes_lo[1], lanes_lo[0]};
    end
  end

  // ----------------------------------------------------------------
  // Register pair write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pair_out      <= 1'b0;
      wr_even_idx_out  <= '0;
      wr_odd_idx_out   <= '0;
      wr_even_data_out <= '0;
      wr_odd_data_out  <= '0;
    end else begin
      wr_pair_out <= res64_valid_in;
      if (res64_valid_in) begin
        wr_even_idx_out  <= {res64_dst_in[`REG_IDX_W-1:1], 1'b0};
        wr_odd_idx_out   <= {res64_dst_in[`REG_IDX_W-1:1], 1'b1};
        wr_even_data_out <= res64_in[`WORD_W-1:0];
        wr_odd_data_out  <= res64_in[2*`WORD_W-1:`WORD_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  AST_GRANT_PERMITTED: assert property (
    issue_out |-> |(unit_grant_out & unit_mask($past(op_class_in))))
    else $error("grant on a unit not permitted");
  AST_ILLEGAL_NO_ISSUE: assert property (
    illegal_out |-> !issue_out && unit_grant_out == '0)
    else $error("illegal instruction issued");
  AST_MULT_ONLY: assert property (
    valid_in && op_class_in == op_galois_quad_multiply &&
    unit_sel_in != unit_mult |=> illegal_out)
    else $error("multiply-only class accepted elsewhere");
  AST_DATA_ONLY: assert property (
    valid_in && op_class_in == op_load_double_unaligned &&
    unit_sel_in == unit_logic |=> illegal_out)
    else $error("data-only class accepted on logic unit");
  AST_SHIFT_ONLY: assert property (
    valid_in && op_class_in == op_packed_compare &&
    unit_sel_in == unit_mult |=> illegal_out)
    else $error("shift-only class accepted on multiply unit");
  AST_LOGIC_ONLY: assert property (
    valid_in && op_class_in == op_octet_swap &&
    unit_sel_in == unit_shift |=> illegal_out)
    else $error("logic-only class accepted on shift unit");
  AST_DUAL_UNIT: assert property (
    valid_in && op_class_in == op_halves_swap &&
    unit_sel_in == unit_data |=> illegal_out)
    else $error("half swap accepted on data unit");
  AST_DATA_LEGACY: assert property (
    valid_in && op_class_in == op_constant_move &&
    unit_sel_in == unit_data && !cross_use_in &&
    instr_word_in[`CREG_MSB:`ZTEST_BIT] == 4'h0 |=> issue_out)
    else $error("constant move refused on data unit");
  AST_PRED_A0: assert property (
    valid_in && instr_word_in[`CREG_MSB:`CREG_LSB] == `CREG_A0 &&
    !instr_word_in[`ZTEST_BIT] && cond_is_zero_in[`CZ_A0]
    |=> !issue_out)
    else $error("nonzero test on zero A0 executed");
  AST_PRED_SQUASH: assert property (
    squash_out |-> !issue_out && !illegal_out)
    else $error("squashed instruction issued");
  AST_CROSS_TYPE: assert property (
    valid_in && cross_use_in && cross_kind_in == xk_other
    |=> illegal_out)
    else $error("cross path allowed for wrong type");
  AST_PAIR_SPLIT: assert property (
    wr_pair_out |-> wr_odd_idx_out[0] && !wr_even_idx_out[0] &&
    wr_odd_data_out == $past(res64_in[2*`WORD_W-1:`WORD_W]))
    else $error("pair write split wrong");
  AST_BITREV: assert property (
    $past(valid_in) |-> bitrev_out[0] == $past(src2_in[`WORD_W-1])
    && bitrev_out[`WORD_W-1] == $past(src2_in[0]))
    else $error("bit reverse end bits wrong");
  AST_HALF_FLAGS: assert property (
    $past(valid_in) && !$past(lanes_octets_in) |-> flags_out[3:2] == 2'h0)
    else $error("half compare set upper flags");

  COV_ISSUE: cover property (issue_out);
  COV_ILLEGAL: cover property (illegal_out);
  COV_SQUASH: cover property (squash_out);
  COV_PAIR: cover property (wr_pair_out);

endmodule : simd_ext_unit_dispatch_decode
`default_nettype wire

// ### fetch_stub.sv
`timescale 1ns/1ps
`default_nettype none

// Dispatch stage stand-in: one word per request, scrambled when idle
module fetch_stub (
  // Request from the bench
  input  wire logic        go_in,
  input  wire logic [3:0]  cond_in,
  // Toward the decoder
  output logic             valid_out,
  output logic [31:0]      word_out
);
  // Word carries selector and zero-test bits on top
  assign valid_out = go_in;
  assign word_out  = go_in ? {cond_in, 28'h0} : ~{cond_in, 28'h5a5a5a5};
endmodule : fetch_stub

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import simd_dispatch_pkg::*;
  logic clk_in, arst_n_in, go, res_v, xuse, sgn, oct, valid, iss, ill, sq;
  logic wrp;
  logic [3:0] cond, gr, fl;
  logic [5:0] cz;
  logic [1:0] lane;
  logic [31:0] s1, s2, pe, po, word, sc, br, wed, wod;
  logic [63:0] r64;
  logic [4:0] dst, wei, woi;
  logic [15:0] bc;
  logic [3:0][16:0] qh;
  op_class_t op;
  unit_t un;
  xkind_t xk;
  ext_kind_t ek;
  cmp_mode_t cm;
  int bad_count, cmp_count;

  fetch_stub src (.go_in(go), .cond_in(cond), .valid_out(valid),
    .word_out(word));
  simd_ext_unit_dispatch_decode dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .valid_in(valid),
    .op_class_in(op), .unit_sel_in(un), .instr_word_in(word),
    .cond_is_zero_in(cz), .cross_use_in(xuse), .cross_kind_in(xk),
    .src1_in(s1), .src2_in(s2), .lanes_signed_in(sgn),
    .lanes_octets_in(oct), .cmp_mode_in(cm), .ext_kind_in(ek),
    .ext_lane_in(lane), .pair_even_in(pe), .pair_odd_in(po),
    .res64_valid_in(res_v), .res64_in(r64), .res64_dst_in(dst),
    .issue_out(iss), .unit_grant_out(gr), .illegal_out(ill),
    .squash_out(sq), .scalar_out(sc), .flags_out(fl), .bitrev_out(br),
    .bitcount_out(bc), .quad_halves_out(qh), .wr_pair_out(wrp),
    .wr_even_idx_out(wei), .wr_odd_idx_out(woi),
    .wr_even_data_out(wed), .wr_odd_data_out(wod));

  // Clock, 4 ns period
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic chk(input logic [74:0] got, input logic [74:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // One request, judged one cycle later: {issue, illegal, squash, grant}
  task automatic disp(input op_class_t o, input unit_t u,
      input logic [3:0] c, input logic [5:0] z, input logic [6:0] e);
    op = o; un = u; cond = c; cz = z; go = 1'b1;
    @(negedge clk_in);
    chk({iss, ill, sq, gr}, e);
  endtask : disp

  task automatic idle(input string n);
    go = 1'b0;
    @(negedge clk_in);
    $display("%s done", n);
  endtask : idle

  task automatic t_units;
    op_class_t o[15] = '{op_rotate, op_rotate, op_load_double_aligned,
      op_branch_decrement, op_octet_swap, op_halves_pack, op_halves_pack,
      op_constant_move, op_packed_compare, op_address_add_doubleword,
      op_galois_quad_multiply, op_load_double_unaligned, op_packed_compare,
      op_octet_swap, op_halves_swap};
    unit_t u[15] = '{unit_mult, unit_logic, unit_data, unit_shift,
      unit_logic, unit_shift, unit_data, unit_data, unit_shift, unit_logic,
      unit_data, unit_logic, unit_mult, unit_shift, unit_data};
    logic [6:0] e[15] = '{7'h42, 7'h20, 7'h48, 7'h44, 7'h41, 7'h44, 7'h20,
      7'h48, 7'h44, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20};
    for (int i = 0; i < 15; i++)
      disp(o[i], u[i], 4'h0, 6'h0, e[i]);
    idle("units");
  endtask : t_units

  task automatic t_pred;
    logic [2:0] sel[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    int ix[6] = '{3, 4, 5, 1, 2, 0};
    logic [5:0] m;
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < 4; k++) begin
        m = 6'h1 << ix[i];
        disp(op_packed_compare, unit_shift, {sel[i], k[0]}, k[1] ? m : ~m,
          (k[0] == k[1]) ? 7'h44 : 7'h10);
      end
    disp(op_rotate, unit_mult, 4'h1, 6'h0, 7'h20);
    disp(op_rotate, unit_mult, 4'he, 6'h0, 7'h20);
    disp(op_rotate, unit_mult, 4'hf, 6'h3f, 7'h20);
    idle("predicate");
  endtask : t_pred

  task automatic t_cross;
    xuse = 1'b1;
    for (int i = 0; i < 4; i++) begin
      xk = xkind_t'(i);
      disp(op_packed_compare, unit_shift, 4'h0, 6'h0,
        (i == 3) ? 7'h20 : 7'h44);
    end
    xuse = 1'b0;
    idle("cross");
  endtask : t_cross

  task automatic t_lanes;
    logic [7:0] b;
    logic [31:0] r;
    logic [7:0] ft[6] = '{8'hce, 8'h82, 8'hd1, 8'h50, 8'h61, 8'he0};
    s1 = 32'h807f0100; s2 = 32'h807f01ff; pe = 32'h80017fff;
    po = 32'hffff0000;
    for (int g = 0; g < 4; g++) begin
      b = s2[8*g +: 8];
      lane = g[1:0];
      ek = signed_octet;
      disp(op_bit_count, unit_mult, 4'h0, 6'h0, 7'h42);
      chk(sc, {{24{b[7]}}, b});
      ek = unsigned_octet;
      disp(op_bit_count, unit_mult, 4'h0, 6'h0, 7'h42);
      chk(sc, {24'h0, b});
    end
    ek = signed_upper_half;
    disp(op_bit_reverse, unit_mult, 4'h0, 6'h0, 7'h42);
    chk(sc, 32'hffff807f);
    ek = unsigned_lower_half;
    disp(op_bit_reverse, unit_mult, 4'h0, 6'h0, 7'h42);
    chk(sc, 32'h000001ff);
    ek = unsigned_upper_half;
    disp(op_bit_reverse, unit_mult, 4'h0, 6'h0, 7'h42);
    chk(sc, 32'h0000807f);
    ek = whole_word;
    disp(op_bit_reverse, unit_mult, 4'h0, 6'h0, 7'h42);
    chk(sc, 32'h807f01ff);
    for (int j = 0; j < 32; j++)
      r[j] = s2[31-j];
    chk(br, r);
    chk(bc, 16'h1718);
    for (int i = 0; i < 6; i++) begin
      sgn = ft[i][7];
      oct = ft[i][6];
      cm = cmp_mode_t'(ft[i][5:4]);
      disp(op_packed_compare, unit_shift, 4'h0, 6'h0, 7'h44);
      chk(fl, ft[i][3:0]);
      chk(qh, {sgn, 16'hffff, 17'h0, sgn, 16'h8001, 17'h07fff});
    end
    idle("lanes");
  endtask : t_lanes

  task automatic t_pair;
    res_v = 1'b1; r64 = 64'h00000001_00000002; dst = 5'h07;
    @(negedge clk_in);
    chk({wrp, wei, woi, wod, wed}, {1'b1, 5'h06, 5'h07, r64});
    r64 = 64'hdeadbeef_01234567; dst = 5'h0a;
    @(negedge clk_in);
    chk({wrp, wei, woi, wod, wed}, {1'b1, 5'h0a, 5'h0b, r64});
    res_v = 1'b0;
    @(negedge clk_in);
    chk(wrp, 1'b0);
    $display("pair done");
  endtask : t_pair

  // Cap on total run length
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    report_and_stop;
  end

  initial begin
    arst_n_in = 1'b0; go = 1'b0; res_v = 1'b0; xuse = 1'b0; sgn = 1'b0;
    oct = 1'b0; cond = 4'h0; cz = 6'h0; op = op_rotate; un = unit_mult;
    xk = xk_int; ek = whole_word; cm = cmp_eq; lane = 2'h0; s1 = 32'h0;
    s2 = 32'h0; pe = 32'h0; po = 32'h0; r64 = 64'h0; dst = 5'h0;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    t_units;
    t_pred;
    t_cross;
    t_lanes;
    t_pair;
    report_and_stop;
  end
endmodule : tb_top

`default_nettype wire
